// File: logic/cfgport_pkg.sv
// constants, types and register layout of the indexed configuration port
package cfgport_pkg;

	localparam int NUM_OUT = 6;
	localparam int BYTE_W = 8;
	localparam int BIT_CNT_W = 4;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	localparam logic [7:0] IDX_ENABLE = 8'h00;
	localparam logic [7:0] IDX_PLL_AMP = 8'h01;
	localparam logic [7:0] IDX_SLEW = 8'h02;
	localparam logic [7:0] IDX_FB_SLEW = 8'h03;
	localparam logic [7:0] IDX_RSVD = 8'h04;
	localparam logic [7:0] IDX_REV = 8'h05;
	localparam logic [7:0] IDX_DEV = 8'h06;
	localparam logic [7:0] IDX_COUNT = 8'h07;

	localparam logic [7:0] RST_ENABLE = 8'hDD;
	localparam logic [7:0] RST_PLL_AMP = 8'h06;
	localparam logic [7:0] RST_SLEW = 8'hDF;
	localparam logic [7:0] RST_FB_SLEW = 8'h87;
	localparam logic [4:0] RST_COUNT = 5'h08;
	localparam logic [7:0] RSVD_READ = 8'hFF;

	localparam logic [7:0] WMASK_ENABLE = 8'hDD;
	localparam logic [7:0] WMASK_PLL_AMP = 8'h3B;
	localparam logic [7:0] WMASK_SLEW = 8'hDD;
	localparam logic [7:0] WMASK_FB_SLEW = 8'h01;

	localparam int POS_SW_OVERRIDE = 5;
	localparam int POS_SW_MODE_LO = 3;
	localparam int POS_AMP_LO = 0;
	localparam int POS_FB_FAST = 0;
	localparam logic [1:0] RST_AMPLITUDE = 2'b10;

	localparam int STRAP_WAIT = 3;
	localparam int FIFO_DEPTH = 8;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX = 3'b001,
		ST_ACK = 3'b011,
		ST_TX = 3'b010,
		ST_HOST_ACK = 3'b110
	} link_state_e;

	typedef enum logic [1:0] {
		KIND_ADDR = 2'b00,
		KIND_INDEX = 2'b01,
		KIND_COUNT = 2'b11,
		KIND_DATA = 2'b10
	} byte_kind_e;

	typedef struct packed {
		logic [7:0] index;
		logic [7:0] data;
	} wr_entry_s;

	typedef struct packed {
		logic [NUM_OUT-1:0] out_run;
		logic [NUM_OUT-1:0] edge_fast;
		logic feedback_edge_fast;
		logic [1:0] amplitude;
		logic [1:0] pll_mode;
	} cfg_out_s;

endpackage

// File: logic/byte_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] used_q;
	logic push;
	logic pop;

	assign o_in_ready = (used_q != (AW+1)'(DEPTH));
	assign o_out_valid = (used_q != '0);
	assign push = i_ce && i_in_valid && o_in_ready;
	assign pop = i_ce && o_out_valid && i_out_ready;
	assign o_out_data = mem_q[rd_ptr_q];

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			used_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
			end
			if (push && !pop) begin
				used_q <= used_q + 1'b1;
			end else if (pop && !push) begin
				used_q <= used_q - 1'b1;
			end
		end
	end

endmodule

// File: logic/smbus_indexed_config_port.sv
// smbus target with indexed block write/read over the configuration bytes
`timescale 1ns/1ps
module smbus_indexed_config_port #(
	parameter logic [6:0] ADDR_BASE = 7'h50,
	parameter logic [7:0] ID_REV = 8'h00,
	parameter logic [7:0] ID_DEV = 8'h00
) (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe,
	input wire logic [1:0] i_address_select_pin,
	input wire logic [1:0] i_pll_mode_pin,
	input wire logic [cfgport_pkg::NUM_OUT-1:0] i_out_enable_n,
	output cfgport_pkg::cfg_out_s o_cfg
);
	import cfgport_pkg::*;

	// ID_REV and ID_DEV values are arbitrary
	localparam int SYNC_W = 2 + 2 + 2 + NUM_OUT;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [NUM_OUT-1:0] out_bits(input logic [7:0] b);
		return {b[7], b[6], b[4], b[3], b[2], b[0]};
	endfunction

	function automatic logic [7:0] masked(input logic [7:0] old, input logic [7:0] val, input logic [7:0] m);
		return (old & ~m) | (val & m);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic [SYNC_W-1:0] pin_meta_q;
	logic [SYNC_W-1:0] pin_q;
	logic scl_s;
	logic sda_s;
	logic scl_prev_q;
	logic sda_prev_q;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_q <= '1;
			pin_q <= '1;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else if (i_ce) begin
			pin_meta_q <= {i_scl, i_sda, i_address_select_pin, i_pll_mode_pin, i_out_enable_n};
			pin_q <= pin_meta_q;
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end
	assign scl_s = pin_q[SYNC_W-1];
	assign sda_s = pin_q[SYNC_W-2];
	assign scl_rise = i_ce && scl_s && !scl_prev_q;
	assign scl_fall = i_ce && !scl_s && scl_prev_q;
	assign start_cond = i_ce && scl_s && scl_prev_q && sda_prev_q && !sda_s;
	assign stop_cond = i_ce && scl_s && scl_prev_q && !sda_prev_q && sda_s;

	////////////////////////////////////////////////////////////////////////////////
	// straps are taken once, after the pin pipeline has settled
	logic [1:0] strap_cnt_q;
	logic strap_done_q;
	logic [6:0] my_addr_q;
	logic [1:0] pll_latched_q;

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			strap_cnt_q <= 2'd0;
			strap_done_q <= 1'b0;
			my_addr_q <= 7'h00;
			pll_latched_q <= 2'b00;
		end else if (i_ce && !strap_done_q) begin
			strap_cnt_q <= strap_cnt_q + 2'd1;
			if (strap_cnt_q == 2'(STRAP_WAIT - 1)) begin
				strap_done_q <= 1'b1;
				my_addr_q <= ADDR_BASE + {5'b0, pin_q[NUM_OUT+3:NUM_OUT+2]};
				pll_latched_q <= pin_q[NUM_OUT+1:NUM_OUT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	logic [7:0] enable_q;
	logic [7:0] pll_amp_q;
	logic [7:0] slew_q;
	logic [7:0] fb_slew_q;
	logic [4:0] count_q;
	wr_entry_s fifo_in;
	wr_entry_s fifo_out;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic drain;
	logic tx_load;

	byte_fifo #(.WIDTH($bits(wr_entry_s)), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
		.i_clk(i_clk_sys),
		.i_rstn(rst_n),
		.i_ce(i_ce),
		.i_in_valid(fifo_in_valid),
		.o_in_ready(fifo_in_ready),
		.i_in_data(fifo_in),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(fifo_out_ready),
		.o_out_data(fifo_out)
	);

	// register writes pause while a read byte is fetched
	assign fifo_out_ready = !tx_load;
	assign drain = i_ce && fifo_out_valid && fifo_out_ready;

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			enable_q <= RST_ENABLE;
			pll_amp_q <= RST_PLL_AMP;
			slew_q <= RST_SLEW;
			fb_slew_q <= RST_FB_SLEW;
			count_q <= RST_COUNT;
		end else if (drain) begin
			case (fifo_out.index)
				IDX_ENABLE: enable_q <= masked(enable_q, fifo_out.data, WMASK_ENABLE);
				IDX_PLL_AMP: pll_amp_q <= masked(pll_amp_q, fifo_out.data, WMASK_PLL_AMP);
				IDX_SLEW: slew_q <= masked(slew_q, fifo_out.data, WMASK_SLEW);
				IDX_FB_SLEW: fb_slew_q <= masked(fb_slew_q, fifo_out.data, WMASK_FB_SLEW);
				IDX_COUNT: count_q <= fifo_out.data[4:0];
				default: begin
				end
			endcase
		end
	end

	function automatic logic [7:0] rd_byte(input logic [7:0] idx);
		case (idx)
			IDX_ENABLE: return enable_q;
			IDX_PLL_AMP: return {pll_latched_q, pll_amp_q[5:0]};
			IDX_SLEW: return slew_q;
			IDX_FB_SLEW: return fb_slew_q;
			IDX_RSVD: return RSVD_READ;
			IDX_REV: return ID_REV;
			IDX_DEV: return ID_DEV;
			IDX_COUNT: return {3'b000, count_q};
			default: return 8'h00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	link_state_e state_q;
	byte_kind_e kind_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic [7:0] tx_byte_q;
	logic [7:0] idx_q;
	logic [4:0] remain_q;
	logic read_q;
	logic ack_q;
	logic host_ack_q;
	logic sda_oe_q;
	logic addr_hit;
	logic byte_done;
	logic [7:0] rd_cur;

	assign addr_hit = strap_done_q && (shift_q[7:1] == my_addr_q);
	assign byte_done = scl_fall && (state_q == ST_RX) && (bit_cnt_q == BITS_PER_BYTE);
	assign fifo_in = '{index: idx_q, data: shift_q};
	assign fifo_in_valid = byte_done && (kind_q == KIND_DATA) && (remain_q != 5'd0);
	assign tx_load = scl_fall && ((state_q == ST_ACK && kind_q == KIND_ADDR && read_q && ack_q)
		|| (state_q == ST_HOST_ACK && host_ack_q));
	always_comb begin
		rd_cur = rd_byte(idx_q);
	end

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			kind_q <= KIND_ADDR;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			tx_byte_q <= 8'h00;
			idx_q <= 8'h00;
			remain_q <= 5'd0;
			read_q <= 1'b0;
			ack_q <= 1'b0;
			host_ack_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else if (start_cond) begin
			state_q <= ST_RX;
			kind_q <= KIND_ADDR;
			bit_cnt_q <= 4'h0;
			sda_oe_q <= 1'b0;
		end else if (stop_cond) begin
			state_q <= ST_IDLE;
			sda_oe_q <= 1'b0;
		end else begin
			case (state_q)
				ST_RX: begin
					if (scl_rise && bit_cnt_q != BITS_PER_BYTE) begin
						shift_q <= {shift_q[6:0], sda_s};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end else if (byte_done) begin
						state_q <= ST_ACK;
						bit_cnt_q <= 4'h0;
						case (kind_q)
							KIND_ADDR: begin
								ack_q <= addr_hit;
								sda_oe_q <= addr_hit;
								read_q <= shift_q[0];
							end
							KIND_INDEX: begin
								idx_q <= shift_q;
								ack_q <= 1'b1;
								sda_oe_q <= 1'b1;
							end
							KIND_COUNT: begin
								remain_q <= shift_q[4:0];
								ack_q <= 1'b1;
								sda_oe_q <= 1'b1;
							end
							default: begin
								ack_q <= fifo_in_valid && fifo_in_ready;
								sda_oe_q <= fifo_in_valid && fifo_in_ready;
								if (fifo_in_valid && fifo_in_ready) begin
									idx_q <= idx_q + 8'h01;
									remain_q <= remain_q - 5'd1;
								end
							end
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (!ack_q) begin
							state_q <= ST_IDLE;
							sda_oe_q <= 1'b0;
						end else if (tx_load) begin
							tx_byte_q <= {3'b000, count_q};
							shift_q <= {2'b00, count_q, 1'b0};
							sda_oe_q <= 1'b1;
							bit_cnt_q <= 4'h1;
							state_q <= ST_TX;
						end else begin
							sda_oe_q <= 1'b0;
							state_q <= ST_RX;
							kind_q <= (kind_q == KIND_ADDR) ? KIND_INDEX
								: (kind_q == KIND_INDEX) ? KIND_COUNT : KIND_DATA;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt_q == BITS_PER_BYTE) begin
							sda_oe_q <= 1'b0;
							state_q <= ST_HOST_ACK;
						end else begin
							sda_oe_q <= !shift_q[7];
							shift_q <= {shift_q[6:0], 1'b0};
							bit_cnt_q <= bit_cnt_q + 4'h1;
						end
					end
				end
				ST_HOST_ACK: begin
					if (scl_rise) begin
						host_ack_q <= !sda_s;
					end else if (tx_load) begin
						tx_byte_q <= rd_cur;
						sda_oe_q <= !rd_cur[7];
						shift_q <= {rd_cur[6:0], 1'b0};
						idx_q <= idx_q + 8'h01;
						bit_cnt_q <= 4'h1;
						state_q <= ST_TX;
					end else if (scl_fall) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
				end
			endcase
		end
	end
	assign o_sda = 1'b0;
	assign o_sda_oe = sda_oe_q;

	////////////////////////////////////////////////////////////////////////////////
	logic [1:0] pll_mode;
	assign pll_mode = pll_amp_q[POS_SW_OVERRIDE] ? pll_amp_q[POS_SW_MODE_LO+:2] : pll_latched_q;
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			o_cfg <= '0;
		end else if (i_ce) begin
			o_cfg.out_run <= out_bits(enable_q) & ~pin_q[NUM_OUT-1:0];
			o_cfg.edge_fast <= out_bits(slew_q);
			o_cfg.feedback_edge_fast <= fb_slew_q[POS_FB_FAST];
			o_cfg.amplitude <= pll_amp_q[POS_AMP_LO+:2];
			o_cfg.pll_mode <= pll_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!rst_n);
	addr_ack_drive_a: assert property (state_q == ST_ACK && ack_q |-> o_sda_oe)
		else $error("ack not driven");
	addr_miss_quiet_a: assert property (byte_done && kind_q == KIND_ADDR && !addr_hit |=> !o_sda_oe)
		else $error("foreign address acknowledged");
	write_consecutive_a: assert property (fifo_in_valid && fifo_in_ready |=> idx_q == $past(idx_q) + 8'h01)
		else $error("write index not advanced");
	count_first_a: assert property (state_q == ST_ACK && tx_load |=> tx_byte_q == {3'b000, count_q})
		else $error("count byte not sent first");
	address_held_a: assert property (strap_done_q && $past(strap_done_q) |-> $stable(my_addr_q))
		else $error("bus address changed");
	enable_override_a: assert property (i_ce && !enable_q[0] |=> !o_cfg.out_run[0])
		else $error("disabled output running");
	pll_source_a: assert property (i_ce && !pll_amp_q[POS_SW_OVERRIDE] |=> o_cfg.pll_mode == $past(pll_latched_q))
		else $error("pll mode source wrong");
	amp_reset_a: assert property ($rose(rst_n) |-> pll_amp_q[1:0] == RST_AMPLITUDE)
		else $error("amplitude reset wrong");
	reserved_ones_a: assert property (state_q == ST_HOST_ACK && tx_load && idx_q == IDX_RSVD |=> tx_byte_q == 8'hFF)
		else $error("reserved byte not ones");
	load_shift_a: assert property (tx_load |=> shift_q == {tx_byte_q[6:0], 1'b0} && o_sda_oe == !tx_byte_q[7])
		else $error("sent bits do not match loaded byte");
endmodule

// File: tb/smbus_host_model.sv
// behavioural smbus host controller driving the configuration port
`timescale 1ns/1ps
module smbus_host_model (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_pull,
	output logic o_res_stb,
	output logic [7:0] o_res_val
);
	localparam realtime QTR = 31.3;
	initial begin
		o_scl = 1'b1;
		o_sda_pull = 1'b0;
		o_res_stb = 1'b0;
		o_res_val = 8'h00;
	end
	////////////////////////////////////////////////////////////////
	// one result strobe per byte, on the system clock
	task automatic post(input logic [7:0] v);
		@(posedge i_clk);
		o_res_val <= v;
		o_res_stb <= 1'b1;
		@(posedge i_clk);
		o_res_stb <= 1'b0;
	endtask
	// data set while scl low, sampled mid-high, scl left low
	task automatic clk_bit(input logic b, output logic s);
		#QTR o_sda_pull = ~b;
		#QTR o_scl = 1'b1;
		#QTR s = i_sda;
		#QTR o_scl = 1'b0;
	endtask
	// start from idle, or repeated start inside a frame
	task automatic start();
		if (!o_scl) begin
			#QTR o_sda_pull = 1'b0;
			#QTR o_scl = 1'b1;
		end
		#QTR o_sda_pull = 1'b1;
		#QTR o_scl = 1'b0;
	endtask
	task automatic stop();
		#QTR o_sda_pull = 1'b1;
		#QTR o_scl = 1'b1;
		#QTR o_sda_pull = 1'b0;
		#QTR;
	endtask
	// posts 1 when the port acknowledged
	task automatic write_byte(input logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(v[i], s);
		end
		clk_bit(1'b1, s);
		post({7'h00, ~s});
	endtask
	// ack every byte but the last, which gets a not-acknowledge
	task automatic read_byte(input logic last);
		logic [7:0] v;
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, s);
			v[i] = s;
		end
		clk_bit(last, s);
		post(v);
	endtask
endmodule

// File: tb/smbus_indexed_config_port_tb.sv
// self-checking testbench for the indexed configuration port
`timescale 1ns/1ps
module smbus_indexed_config_port_tb;
	import cfgport_pkg::*;
	localparam logic [6:0] BASE = 7'h50;
	localparam logic [7:0] ID_A = 8'h3C; // arbitrary value
	localparam logic [7:0] ID_B = 8'h5A; // arbitrary value
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic scl;
	logic sda_pull;
	logic sda_o;
	logic sda_oe;
	logic sda_wire;
	logic [1:0] addr_pin;
	logic [1:0] pll_pin;
	logic [5:0] oe_n;
	cfg_out_s cfg;
	logic res_stb;
	logic [7:0] res_val;
	logic [7:0] shadow [0:255];
	logic [7:0] exp_q [$];
	logic [6:0] dev_addr;
	integer seed = 32'h2B88;
	int mismatches = 0;
	int check_count = 0;
	always #4 clk = ~clk;
	// open drain wire with pull-up
	assign sda_wire = (sda_oe ? sda_o : 1'b1) & ~sda_pull;
	smbus_indexed_config_port #(.ADDR_BASE(BASE), .ID_REV(ID_A), .ID_DEV(ID_B)) u_smbus_indexed_config_port (
		.i_clk_sys(clk), .i_rstn(rstn), .i_ce(1'b1), .i_scl(scl), .i_sda(sda_wire), .o_sda(sda_o),
		.o_sda_oe(sda_oe), .i_address_select_pin(addr_pin), .i_pll_mode_pin(pll_pin),
		.i_out_enable_n(oe_n), .o_cfg(cfg));
	smbus_host_model u_host (.i_clk(clk), .i_sda(sda_wire), .o_scl(scl), .o_sda_pull(sda_pull),
		.o_res_stb(res_stb), .o_res_val(res_val));
	////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		if (mismatches == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic check_byte(input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH bus_byte expected %h seen %h", e, g);
		end
	endtask
	task automatic check_cfg(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	// oldest note against each byte the host reports
	always @(posedge clk) begin
		if (res_stb === 1'b1) begin
			check_byte(exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX, res_val);
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic send(input logic [7:0] v, input logic [7:0] ack);
		exp_q.push_back(ack);
		u_host.write_byte(v);
	endtask
	task automatic store(input logic [7:0] i, input logic [7:0] v);
		logic [7:0] m;
		m = i == 8'h00 ? WMASK_ENABLE : i == 8'h01 ? WMASK_PLL_AMP : i == 8'h02 ? WMASK_SLEW : WMASK_FB_SLEW;
		if (i < 8'h04) begin
			shadow[i] = (v & m) | (shadow[i] & ~m);
		end else if (i == IDX_COUNT) begin
			shadow[i] = {3'h0, v[4:0]};
		end
	endtask
	task automatic blk_write(input logic [7:0] n, input logic [7:0] d[$], input int extra);
		u_host.start();
		send({dev_addr, 1'b0}, 8'h01);
		send(n, 8'h01);
		send(8'(d.size()), 8'h01);
		foreach (d[k]) begin
			send(d[k], 8'h01);
			store(8'(n + k), d[k]);
		end
		repeat (extra) send(8'h5A, 8'h00);
		u_host.stop();
		repeat (30) @(posedge clk);
	endtask
	task automatic blk_read(input logic [7:0] n, input int cnt);
		u_host.start();
		send({dev_addr, 1'b0}, 8'h01);
		send(n, 8'h01);
		u_host.start();
		send({dev_addr, 1'b1}, 8'h01);
		exp_q.push_back(shadow[7]);
		u_host.read_byte(1'b0);
		for (int k = 0; k < cnt; k++) begin
			exp_q.push_back(shadow[8'(n + k)]);
			u_host.read_byte(k == cnt - 1);
		end
		u_host.stop();
		repeat (30) @(posedge clk);
	endtask
	task automatic check_outputs();
		repeat (10) @(posedge clk);
		check_cfg("out_run", {2'h0, shadow[0][7:6], shadow[0][4:2], shadow[0][0]} & ~{2'h0, oe_n},
			{2'h0, cfg.out_run});
		check_cfg("edge_fast", {2'h0, shadow[2][7:6], shadow[2][4:2], shadow[2][0]}, {2'h0, cfg.edge_fast});
		check_cfg("fb_fast", {7'h00, shadow[3][0]}, {7'h00, cfg.feedback_edge_fast});
		check_cfg("amplitude", {6'h00, shadow[1][1:0]}, {6'h00, cfg.amplitude});
		check_cfg("pll_mode", {6'h00, shadow[1][5] ? shadow[1][4:3] : pll_pin}, {6'h00, cfg.pll_mode});
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		addr_pin = 2'($unsigned($random(seed)) % 3);
		pll_pin = 2'($random(seed));
		oe_n = 6'h00;
		for (int k = 0; k < 256; k++) begin
			shadow[k] = 8'h00;
		end
		shadow[0] = RST_ENABLE;
		shadow[1] = RST_PLL_AMP | {pll_pin, 6'h00};
		shadow[2] = RST_SLEW;
		shadow[3] = RST_FB_SLEW;
		shadow[4] = RSVD_READ;
		shadow[5] = ID_A;
		shadow[6] = ID_B;
		shadow[7] = {3'h0, RST_COUNT};
		dev_addr = BASE + 7'(addr_pin);
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (12) @(posedge clk);
		addr_pin <= 2'((addr_pin + 2'h1) % 3);
		repeat (20) @(posedge clk);
		check_outputs();
		blk_read(8'h00, 8);
		// addresses other than the latched one stay unanswered
		u_host.start();
		send({BASE + 7'(addr_pin), 1'b0}, 8'h00);
		u_host.stop();
		u_host.start();
		send({BASE + 7'h03, 1'b0}, 8'h00);
		u_host.stop();
		repeat (4) begin
			blk_write(8'h00, {8'($random(seed)), 8'($random(seed)), 8'($random(seed)), 8'($random(seed))}, 0);
			oe_n <= 6'($random(seed));
			check_outputs();
			blk_read(8'h00, 4);
		end
		for (int m = 0; m < 4; m++) begin
			blk_write(8'h01, {8'h20 | 8'(m * 9)}, 0);
			check_outputs();
		end
		blk_write(8'h01, {8'h1A}, 0);
		check_outputs();
		// index 4 write ignored, byte past the count refused
		blk_write(8'h03, {8'h00, 8'h00}, 1);
		blk_read(8'h03, 2);
		check_outputs();
		blk_write(8'h07, {8'hE5}, 0);
		blk_read(8'h06, 2);
		print_verdict();
	end
	initial begin
		#400_000;
		mismatches++;
		print_verdict();
	end
endmodule
